// *** rtl/psirp_pkg.sv ***
package psirp_pkg;

    localparam logic [6:0] DEV_ADDR      = 7'h77;
    localparam logic [7:0] REG_CTRL      = 8'hF4;
    localparam logic [7:0] REG_SOFTRST   = 8'hE0;
    localparam logic [7:0] REG_PART      = 8'hD0;
    localparam logic [7:0] REG_RES_LO    = 8'hF6;
    localparam logic [7:0] REG_RES_HI    = 8'hF7;
    localparam logic [7:0] CALIB_FIRST   = 8'hAA;
    localparam logic [7:0] CALIB_LAST    = 8'hBF;
    localparam int         CALIB_COUNT   = 22;
    localparam logic [7:0] SOFT_RST_KEY  = 8'hB6;
    localparam logic [7:0] CTRL_RESET    = 8'h00;
    localparam logic [7:0] RES_HI_RESET  = 8'h80;
    localparam logic [7:0] RES_LO_RESET  = 8'h00;
    localparam logic [7:0] READ_FILL     = 8'h00;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    localparam logic [7:0] CMD_TEMP      = 8'h2E;
    localparam logic [7:0] CMD_PRESS_OS0 = 8'h34;
    localparam logic [7:0] CMD_PRESS_OS1 = 8'h74;
    localparam logic [7:0] CMD_PRESS_OS2 = 8'hB4;
    localparam logic [7:0] CMD_PRESS_OS3 = 8'hF4;

    // Field layout of the measurement command register, msb first
    typedef struct packed {
        logic [1:0] oss;
        logic       sco;
        logic [4:0] cmd;
    } psirp_ctrl_t;

    typedef struct packed {
        logic [7:0] hi;
        logic [7:0] lo;
    } psirp_result_t;

    typedef logic [CALIB_COUNT-1:0][7:0] psirp_calib_t;

    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_RX   = 5'b00010,
        ST_ACK  = 5'b00100,
        ST_TX   = 5'b01000,
        ST_MACK = 5'b10000
    } psirp_state_t;

endpackage

// *** rtl/psirp_top.sv ***
// Summary of operation
// - Writable registers reset to defaults every power-on.
// - Command register low five bits select measurement.
// - Busy bit holds until result bytes loaded.
// - Bits 7:6 select pressure oversampling ratio.
// - Writing B6h to E0h resets like power-on.
// - Part code register returns fixed constant.
// - Result bytes readable in either order.
// - Single and burst reads both supported.
// - Standard, fast and high-speed bus rates.
// - Lines only pulled low, never driven high.
// - Answers only target address 1110111.
// - Own address acknowledged on ninth clock.
// - Start and stop conditions detected.
// - Data changes only while clock low.
// - Every received data byte is acknowledged.
// - Command codes 2Eh, 34h, 74h, B4h, F4h.
// - AAh to BFh hold 22 calibration bytes.
// - Each raw result is sixteen bits wide.
// - Calibration word high byte at odd address.
module psirp_top
    import psirp_pkg::*;
#(
    parameter logic [7:0] PART_CODE = 8'hA5  // Arbitrary value
) (
    input  wire logic          clk_in,
    input  wire logic          rstn_in,
    input  wire logic          scl_in,
    output logic               scl_out,
    output logic               scl_oe_out,
    input  wire logic          sda_in,
    output logic               sda_out,
    output logic               sda_oe_out,
    input  wire psirp_calib_t  calib_in,
    input  wire logic          conv_done_in,
    input  wire logic [15:0]   conv_data_in,
    output logic               conv_start_out,
    output logic [4:0]         conv_cmd_out,
    output logic [1:0]         conv_oss_out,
    output logic               busy_out
);

    logic [1:0]    rst_sync;
    logic          rst_n;
    logic [1:0]    scl_sync;
    logic [1:0]    sda_sync;
    logic          scl_q;
    logic          sda_q;
    logic          scl_rise;
    logic          scl_fall;
    logic          start_det;
    logic          stop_det;
    psirp_state_t  state;
    logic [3:0]    bit_cnt;
    logic [7:0]    shreg;
    logic          first_byte;
    logic          reg_byte;
    logic          rw;
    logic          nack;
    logic [7:0]    ptr;
    logic          sda_oe;
    logic          pull_low;
    logic          byte_done;
    logic          addr_hit;
    logic          wr_event;
    logic          ctrl_wr;
    logic          srst_wr;
    logic          soft_rst;
    logic [7:0]    rd_byte;
    logic [4:0]    cal_idx;
    psirp_ctrl_t   ctrl;
    psirp_result_t result;

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    // Pins are asynchronous to clk_in; only stage two feeds logic.
    // At 20 MHz a 3.4 MHz clock leaves about three samples per phase,
    // so high-speed mode works only with clean, symmetric edges.
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            scl_sync <= 2'h3;
            sda_sync <= 2'h3;
            scl_q    <= 1'b1;
            sda_q    <= 1'b1;
        end else begin
            scl_sync <= {scl_sync[0], scl_in};
            sda_sync <= {sda_sync[0], sda_in};
            scl_q    <= scl_sync[1];
            sda_q    <= sda_sync[1];
        end
    end

    assign scl_rise  = scl_sync[1] & ~scl_q;
    assign scl_fall  = ~scl_sync[1] & scl_q;
    assign start_det = scl_sync[1] & scl_q & sda_q & ~sda_sync[1];
    assign stop_det  = scl_sync[1] & scl_q & ~sda_q & sda_sync[1];

    assign byte_done = (state == ST_RX) && scl_fall && (bit_cnt == BITS_PER_BYTE);
    assign addr_hit  = first_byte && (shreg[7:1] == DEV_ADDR);
    assign wr_event  = byte_done && !first_byte && !reg_byte;
    assign ctrl_wr   = wr_event && (ptr == REG_CTRL);
    assign srst_wr   = wr_event && (ptr == REG_SOFTRST) && (shreg == SOFT_RST_KEY);
    assign cal_idx   = 5'(ptr - CALIB_FIRST);

    always_comb begin
        rd_byte = READ_FILL;
        case (ptr)
            REG_RES_HI: rd_byte = result.hi;
            REG_RES_LO: rd_byte = result.lo;
            REG_CTRL:   rd_byte = ctrl;
            REG_PART:   rd_byte = PART_CODE;
            default: begin
                if (ptr >= CALIB_FIRST && ptr <= CALIB_LAST) begin
                    rd_byte = calib_in[cal_idx];
                end
            end
        endcase
    end

    // Bus target; SDA changes only on a seen falling SCL edge, or is released on a start or stop
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            state      <= ST_IDLE;
            bit_cnt    <= 4'h0;
            shreg      <= 8'h00;
            first_byte <= 1'b0;
            reg_byte   <= 1'b0;
            rw         <= 1'b0;
            nack       <= 1'b0;
            ptr        <= 8'h00;
            sda_oe     <= 1'b0;
        end else if (start_det) begin
            state      <= ST_RX;
            bit_cnt    <= 4'h0;
            first_byte <= 1'b1;
            reg_byte   <= 1'b0;
            sda_oe     <= 1'b0;
        end else if (stop_det) begin
            state  <= ST_IDLE;
            sda_oe <= 1'b0;
        end else begin
            case (state)
                ST_IDLE: begin
                    sda_oe <= 1'b0;
                end
                ST_RX: begin
                    if (scl_rise && bit_cnt != BITS_PER_BYTE) begin
                        shreg   <= {shreg[6:0], sda_sync[1]};
                        bit_cnt <= bit_cnt + 4'h1;
                    end
                    if (byte_done) begin
                        first_byte <= 1'b0;
                        reg_byte   <= first_byte & ~shreg[0];
                        if (first_byte && !addr_hit) begin
                            state <= ST_IDLE;
                        end else begin
                            state  <= ST_ACK;
                            sda_oe <= 1'b1;
                        end
                        if (first_byte) begin
                            rw <= shreg[0];
                        end else if (reg_byte) begin
                            ptr <= shreg;
                        end else begin
                            ptr <= ptr + 8'h01;
                        end
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        bit_cnt <= 4'h0;
                        if (rw) begin
                            state   <= ST_TX;
                            sda_oe  <= ~rd_byte[7];
                            shreg   <= {rd_byte[6:0], 1'b0};
                            bit_cnt <= 4'h1;
                        end else begin
                            state  <= ST_RX;
                            sda_oe <= 1'b0;
                        end
                    end
                end
                ST_TX: begin
                    if (scl_fall) begin
                        if (bit_cnt == BITS_PER_BYTE) begin
                            state  <= ST_MACK;
                            sda_oe <= 1'b0;
                        end else begin
                            sda_oe  <= ~shreg[7];
                            shreg   <= {shreg[6:0], 1'b0};
                            bit_cnt <= bit_cnt + 4'h1;
                        end
                    end
                end
                ST_MACK: begin
                    if (scl_rise) begin
                        nack <= sda_sync[1];
                        if (!sda_sync[1]) begin
                            ptr <= ptr + 8'h01;
                        end
                    end
                    if (scl_fall) begin
                        if (nack) begin
                            state <= ST_IDLE;
                        end else begin
                            state   <= ST_TX;
                            sda_oe  <= ~rd_byte[7];
                            shreg   <= {rd_byte[6:0], 1'b0};
                            bit_cnt <= 4'h1;
                        end
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // Never drives high; clock stretching is not used
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            pull_low <= 1'b0;
        end else begin
            pull_low <= 1'b0;
        end
    end
    assign sda_out    = pull_low;
    assign scl_out    = pull_low;
    assign scl_oe_out = pull_low;
    assign sda_oe_out = sda_oe;

    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            soft_rst <= 1'b0;
        end else begin
            soft_rst <= srst_wr;
        end
    end

    // Busy set by a command write wins over a same-cycle completion
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            ctrl <= psirp_ctrl_t'(CTRL_RESET);
        end else if (soft_rst) begin
            ctrl <= psirp_ctrl_t'(CTRL_RESET);
        end else if (ctrl_wr) begin
            ctrl     <= psirp_ctrl_t'(shreg);
            ctrl.sco <= 1'b1;
        end else if (conv_done_in) begin
            ctrl.sco <= 1'b0;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            result <= {RES_HI_RESET, RES_LO_RESET};
        end else if (soft_rst) begin
            result <= {RES_HI_RESET, RES_LO_RESET};
        end else if (conv_done_in && ctrl.sco) begin
            result <= psirp_result_t'(conv_data_in);
        end
    end

    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            conv_start_out <= 1'b0;
        end else begin
            conv_start_out <= ctrl_wr && !soft_rst;
        end
    end
    assign conv_cmd_out = ctrl.cmd;
    assign conv_oss_out = ctrl.oss;
    assign busy_out     = ctrl.sco;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n);

    chk_sda_change_low: assert property (
        $changed(sda_oe) |-> $past(scl_fall || start_det || stop_det))
        else $error("SDA changed while SCL high");
    chk_addr_ack: assert property (
        (byte_done && addr_hit) |=> (sda_oe && state == ST_ACK))
        else $error("Own address not acknowledged");
    chk_addr_ignore: assert property (
        (byte_done && first_byte && !addr_hit) |=> (!sda_oe && state == ST_IDLE))
        else $error("Foreign address answered");
    chk_data_ack: assert property (
        wr_event |=> sda_oe ##1 (sda_oe || $past(scl_fall || start_det || stop_det)))
        else $error("Data byte not acknowledged");
    chk_busy_set: assert property (
        (ctrl_wr && !soft_rst) |=> (ctrl.sco && conv_start_out && ctrl.cmd == $past(shreg[4:0])
            && ctrl.oss == $past(shreg[7:6])))
        else $error("Command write did not start conversion");
    chk_busy_clear: assert property (
        $fell(ctrl.sco) |-> ($past(conv_done_in) || $past(soft_rst)))
        else $error("Busy cleared without result");
    chk_result_load: assert property (
        (conv_done_in && ctrl.sco && !soft_rst) |=> result == $past(conv_data_in))
        else $error("Result not loaded on completion");
    chk_soft_reset: assert property (
        srst_wr |=> ##1 (ctrl == CTRL_RESET && result == {RES_HI_RESET, RES_LO_RESET}))
        else $error("Soft reset did not restore defaults");
    chk_part_code: assert property (
        (state == ST_ACK && scl_fall && rw && ptr == REG_PART) |=> sda_oe == ~PART_CODE[7])
        else $error("Part code first bit wrong");
    chk_never_high: assert property (
        !sda_out && !scl_out && !scl_oe_out)
        else $error("Line driven high");
    chk_start_pulse: assert property (
        conv_start_out |=> !conv_start_out)
        else $error("Converter start longer than one cycle");
    chk_busy_hold: assert property (
        (ctrl.sco && !conv_done_in && !soft_rst) |=> ctrl.sco)
        else $error("Busy cleared before result loaded");
    chk_result_hold: assert property (
        (!conv_done_in && !soft_rst) |=> $stable(result))
        else $error("Result changed without completion");
    chk_cmd_hold: assert property (
        (!ctrl_wr && !soft_rst) |=> $stable({ctrl.oss, ctrl.cmd}))
        else $error("Command field changed without write");

    cov_temp_cmd: cover property (ctrl_wr && shreg == CMD_TEMP);
    cov_press_os3: cover property (ctrl_wr && shreg == CMD_PRESS_OS3);
    cov_burst_read: cover property (state == ST_MACK && scl_fall && !nack);
    cov_soft_reset: cover property (soft_rst);
    cov_foreign_addr: cover property (byte_done && first_byte && !addr_hit);

endmodule

// *** testbench/psirp_host.sv ***
module psirp_host (
    output logic       scl_out,
    output logic       sda_out,
    input  wire logic  sda_in,
    output logic       seen_out,
    output logic [7:0] seen_val_out
);
    timeunit 1ns;
    timeprecision 1ps;

    // Four system clocks per phase, one more than the least the sampler can follow
    localparam int HALF = 200;
    localparam int QTR  = 100;

    initial begin
        scl_out = 1'b1;
        sda_out = 1'b1;
        seen_out = 1'b0;
        seen_val_out = 8'h00;
    end

    // Sample late in the high phase, clear of the target's sync lag
    task automatic bit_io(input logic b, output logic r);
        #QTR sda_out <= b;
        #QTR scl_out <= 1'b1;
        #(HALF - 10) r = sda_in;
        #10 scl_out <= 1'b0;
    endtask

    task automatic report(input logic [7:0] v);
        seen_val_out = v;
        seen_out = 1'b1;
        #1 seen_out = 1'b0;
    endtask

    task automatic start();
        if (!scl_out) begin
            #QTR sda_out <= 1'b1;
            #QTR scl_out <= 1'b1;
        end
        #HALF sda_out <= 1'b0;
        #HALF scl_out <= 1'b0;
    endtask

    // Clock left high: it stands still between frames
    task automatic stop();
        #QTR sda_out <= 1'b0;
        #QTR scl_out <= 1'b1;
        #HALF sda_out <= 1'b1;
        #HALF;
    endtask

    task automatic wbyte(input logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(b[i], r);
        end
        bit_io(1'b1, r);
        report({7'h00, r});
    endtask

    task automatic rbyte(input logic last);
        logic [7:0] v;
        logic       r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, v[i]);
        end
        bit_io(last, r);
        report(v);
    endtask
endmodule

// *** testbench/tb_top.sv ***
module tb_top
    import psirp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [7:0] PART_VAL = 8'h3C; // Arbitrary value

    typedef struct {
        string      nm;
        logic [7:0] v;
    } psirp_note_t;

    logic         clk_in = 1'b0;
    logic         rstn_in = 1'b0;
    psirp_calib_t calib = '0;
    logic         done = 1'b0;
    logic [15:0]  cdata = 16'h0000;
    logic         scl_oe, sda_oe, scl_o, sda_o, start, busy, seen, h_scl, h_sda;
    logic [4:0]   cmd;
    logic [1:0]   oss;
    logic [7:0]   seen_val;
    logic [7:0]   ex[$];
    logic [7:0]   cmds[5] = '{CMD_TEMP, CMD_PRESS_OS0, CMD_PRESS_OS1, CMD_PRESS_OS2, CMD_PRESS_OS3};
    int           fail_count = 0;
    int           n_compared = 0;
    psirp_note_t  link_q[$];
    psirp_note_t  conv_q[$];
    wire logic    scl_line = scl_oe ? (h_scl & scl_o) : h_scl;
    wire logic    sda_line = sda_oe ? (h_sda & sda_o) : h_sda;

    initial begin
        forever #25 clk_in = ~clk_in;
    end

    psirp_top #(.PART_CODE(PART_VAL)) i_psirp_top (
        .clk_in(clk_in), .rstn_in(rstn_in), .scl_in(scl_line), .scl_out(scl_o),
        .scl_oe_out(scl_oe), .sda_in(sda_line), .sda_out(sda_o), .sda_oe_out(sda_oe),
        .calib_in(calib), .conv_done_in(done), .conv_data_in(cdata),
        .conv_start_out(start), .conv_cmd_out(cmd), .conv_oss_out(oss), .busy_out(busy)
    );

    psirp_host i_psirp_host (
        .scl_out(h_scl), .sda_out(h_sda), .sda_in(sda_line),
        .seen_out(seen), .seen_val_out(seen_val)
    );

    task automatic compare(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic take(ref psirp_note_t q[$], input logic [7:0] g);
        psirp_note_t n;
        n = '{"unexpected result", 8'hXX};
        if (q.size() > 0) n = q.pop_front();
        compare(n.nm, n.v, g);
    endtask

    always @(posedge seen) take(link_q, seen_val);
    always @(posedge clk_in) if (start === 1'b1) take(conv_q, {busy, oss, cmd});

    task automatic note(input string nm, input logic [7:0] v);
        link_q.push_back('{nm, v});
    endtask

    task automatic wr(input logic [6:0] da, input logic [7:0] ra, input logic [7:0] d);
        logic ok;
        ok = (da === DEV_ADDR);
        i_psirp_host.start();
        note("address ack", {7'h00, ~ok});
        i_psirp_host.wbyte({da, 1'b0});
        if (ok) begin
            note("register ack", 8'h00);
            i_psirp_host.wbyte(ra);
            note("data ack", 8'h00);
            i_psirp_host.wbyte(d);
        end
        i_psirp_host.stop();
    endtask

    task automatic rd(input string nm, input logic [7:0] ra, input logic [7:0] e[$]);
        i_psirp_host.start();
        note("address ack", 8'h00);
        i_psirp_host.wbyte({DEV_ADDR, 1'b0});
        note("register ack", 8'h00);
        i_psirp_host.wbyte(ra);
        i_psirp_host.start();
        note("read address ack", 8'h00);
        i_psirp_host.wbyte({DEV_ADDR, 1'b1});
        foreach (e[i]) begin
            note(nm, e[i]);
            i_psirp_host.rbyte(i == e.size() - 1);
        end
        i_psirp_host.stop();
    endtask

    task automatic end_of_test();
        if (link_q.size() + conv_q.size() > 0) fail_count++; // Results that never came
        $display("Compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        repeat (100000) @(posedge clk_in);
        fail_count++;
        end_of_test();
    end

    initial begin
        logic [7:0]  c;
        logic [15:0] d;
        void'($urandom(57));
        repeat (6) @(posedge clk_in);
        for (int i = 0; i < CALIB_COUNT; i++) calib[i] <= 8'($urandom);
        rstn_in <= 1'b1;
        repeat (10) @(posedge clk_in); // Scaled down to keep the run short
        rd("part code", REG_PART, {PART_VAL});
        wr(7'h76, REG_CTRL, CMD_TEMP);
        rd("reset values", REG_CTRL, {CTRL_RESET, READ_FILL, RES_LO_RESET, RES_HI_RESET});
        ex = {};
        for (int i = 0; i < CALIB_COUNT; i++) ex.push_back(calib[i]);
        rd("calibration", CALIB_FIRST, ex);
        foreach (cmds[i]) begin
            c = cmds[i];
            d = 16'($urandom);
            conv_q.push_back('{"converter start", {1'b1, c[7:6], c[4:0]}});
            wr(DEV_ADDR, REG_CTRL, c);
            rd("busy flag set", REG_CTRL, {c | 8'h20});
            @(posedge clk_in);
            done <= 1'b1;
            cdata <= d;
            @(posedge clk_in);
            done <= 1'b0;
            rd("busy flag clear", REG_CTRL, {c & 8'hDF});
            if (i % 2) begin
                rd("result high", REG_RES_HI, {d[15:8]});
                rd("result low", REG_RES_LO, {d[7:0]});
            end else begin
                rd("result burst", REG_RES_LO, {d[7:0], d[15:8]});
            end
        end
        // Completion while idle must leave the result alone
        @(posedge clk_in);
        done <= 1'b1;
        cdata <= ~d;
        @(posedge clk_in);
        done <= 1'b0;
        rd("result kept", REG_RES_LO, {d[7:0], d[15:8]});
        wr(DEV_ADDR, REG_SOFTRST, SOFT_RST_KEY - 8'h01);
        rd("no reset on wrong key", REG_CTRL, {c & 8'hDF});
        wr(DEV_ADDR, REG_SOFTRST, SOFT_RST_KEY);
        rd("after soft reset", REG_CTRL, {CTRL_RESET, READ_FILL, RES_LO_RESET, RES_HI_RESET});
        rd("write-only read", REG_SOFTRST, {READ_FILL});
        // Power cycle mid-run: written command must not survive
        conv_q.push_back('{"converter start", {1'b1, CMD_TEMP[7:6], CMD_TEMP[4:0]}});
        wr(DEV_ADDR, REG_CTRL, CMD_TEMP);
        @(posedge clk_in);
        rstn_in <= 1'b0;
        repeat (6) @(posedge clk_in);
        rstn_in <= 1'b1;
        repeat (10) @(posedge clk_in);
        rd("power-on defaults", REG_CTRL, {CTRL_RESET, READ_FILL, RES_LO_RESET, RES_HI_RESET});
        repeat (4) @(posedge clk_in);
        end_of_test();
    end
endmodule
